// ===== hdl/slr_pkg.sv
`default_nettype none
package slr_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_UPPER = 8'h02;
  localparam logic [7:0] ADDR_LOWER = 8'h03;
  localparam logic [7:0] ADDR_UNLOCK = 8'h04;
  localparam logic [7:0] ADDR_SCRATCH1 = 8'h05;
  localparam logic [7:0] ADDR_SCRATCH2 = 8'h06;

  // ------------------------------------------------------------
  // field positions and values after reset
  // ------------------------------------------------------------
  localparam int UNLOCK_BIT = 15;
  localparam int BUSY_BIT = 14;
  localparam logic [15:0] RST_UPPER = 16'h6000;
  localparam logic [15:0] RST_LOWER = 16'h8000;
  localparam logic [15:0] RST_SCRATCH1 = 16'h0000;
  localparam logic [15:0] RST_SCRATCH2 = 16'h0000;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // ------------------------------------------------------------
  // timing, in microseconds, and the clock rate
  // ------------------------------------------------------------
  localparam longint CLK_MHZ = 250;
  localparam longint T_15M5_US = 15500;
  localparam longint T_125M_US = 125000;
  localparam longint T_250M_US = 250000;
  localparam longint T_500M_US = 500000;
  localparam longint T_1S_US = 1000000;
  localparam longint T_4S_US = 4000000;
  localparam longint T_8S_US = 8000000;
  localparam longint T_16S_US = 16000000;
  localparam longint T_AVG1_US = 0;
  localparam longint T_PROG_US = 7000;
  localparam longint T_RELOAD_US = 1500;

  // nvm cell index
  localparam int NVM_WORDS = 4;
  localparam logic [1:0] CELL_UPPER = 2'h0;
  localparam logic [1:0] CELL_LOWER = 2'h1;
  localparam logic [1:0] CELL_SCR1 = 2'h2;
  localparam logic [1:0] CELL_SCR2 = 2'h3;

  typedef enum logic [1:0] {
    SLR_IDLE = 2'b00,
    SLR_RELOAD = 2'b01,
    SLR_PROG = 2'b11
  } slr_nvm_state_t;

  function automatic logic [31:0] us_to_cyc(input longint us);
    return 32'(us * CLK_MHZ);
  endfunction

endpackage

`default_nettype wire

// ===== hdl/slr_limit_nvm.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - continuous cycle period from three-bit code
// - averaging time stretches cycle, no standby
// - sixteen-bit upper threshold, compared each result
// - upper threshold reloaded from nvm, factory 6000h
// - lower threshold reloaded from nvm, factory 8000h
// - sixteen-bit lower threshold, compared each result
// - locked writes touch only logic register
// - unlocked writes start programming matching cell when not busy
// - busy readable as unlock bit 14, mirrored out
// - busy high during programming or reload
// - first scratch word, locked/unlocked write behaviour
// - scratch cells preloaded with unique identifier
// - second scratch word behaves like first
// - averaging code selects 1, 8, 32, 64
// - over flag when result above upper
// - under flag when result below lower
module slr_limit_nvm
  import slr_pkg::*;
#(
  parameter logic [31:0] PERIOD_CYC [8] = '{us_to_cyc(T_15M5_US), us_to_cyc(T_125M_US),
    us_to_cyc(T_250M_US), us_to_cyc(T_500M_US), us_to_cyc(T_1S_US), us_to_cyc(T_4S_US),
    us_to_cyc(T_8S_US), us_to_cyc(T_16S_US)},
  parameter logic [31:0] AVG_MIN_CYC [4] = '{us_to_cyc(T_AVG1_US), us_to_cyc(T_125M_US),
    us_to_cyc(T_500M_US), us_to_cyc(T_1S_US)},
  parameter logic [31:0] PROG_CYC = slr_pkg::us_to_cyc(slr_pkg::T_PROG_US),
  parameter logic [31:0] RELOAD_CYC = slr_pkg::us_to_cyc(slr_pkg::T_RELOAD_US),
  // identifier values below are arbitrary
  parameter logic [15:0] SCRATCH1_ID = 16'h5a01,
  parameter logic [15:0] SCRATCH2_ID = 16'h5a02
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic gcall_reset,
  input wire logic continuous_conversion,
  input wire logic [2:0] cycle_period_select,
  input wire logic [1:0] average_count_select,
  input wire logic result_valid,
  input wire logic [15:0] result_data,
  input wire logic flags_clear,
  output logic cycle_start,
  output logic over_flag,
  output logic under_flag,
  output logic nvm_busy,
  input wire logic link_clk,
  input wire logic link_req,
  input wire logic link_we,
  input wire logic [7:0] link_addr,
  input wire logic [15:0] link_wdata,
  output logic link_ack,
  output logic link_pending,
  output logic [15:0] link_rdata
);
  import slr_pkg::*;
  if (PROG_CYC < 32'h1 || RELOAD_CYC < 32'h1) begin : g_chk_nvm
    $error("nvm timing counts must be at least one cycle");
  end
  for (genvar i = 0; i < 8; i++) begin : g_chk_per
    if (PERIOD_CYC[i] < 32'h1) begin : g_bad
      $error("cycle period counts must be at least one cycle");
    end
  end
  // ------------------------------------------------------------
  // link side: request capture and toggle handshake
  // ------------------------------------------------------------
  logic lk_pend_reg, lk_pend_next, lk_tgl_reg, lk_tgl_next, lk_we_reg, lk_we_next;
  logic [7:0] lk_addr_reg, lk_addr_next;
  logic [15:0] lk_wdata_reg, lk_wdata_next, lk_rdata_reg, lk_rdata_next, cr_rdata_reg;
  logic lk_ack_reg, lk_ack_next, ak_s1_reg, ak_s2_reg, ak_s3_reg, ak_seen_reg, ak_seen_next;
  logic ak_evt, cr_tgl_reg;
  always_comb begin
    ak_evt = (ak_s2_reg == ak_s3_reg) && (ak_s2_reg != ak_seen_reg);
    ak_seen_next = ak_evt ? ak_s2_reg : ak_seen_reg;
    lk_pend_next = lk_pend_reg;
    lk_tgl_next = lk_tgl_reg;
    lk_we_next = lk_we_reg;
    lk_addr_next = lk_addr_reg;
    lk_wdata_next = lk_wdata_reg;
    lk_ack_next = 1'b0;
    lk_rdata_next = lk_rdata_reg;
    if (ak_evt) begin
      // core read data is stable until the next request is raised
      lk_pend_next = 1'b0;
      lk_ack_next = 1'b1;
      lk_rdata_next = cr_rdata_reg;
    end else if (link_req && !lk_pend_reg) begin
      lk_pend_next = 1'b1;
      lk_tgl_next = ~lk_tgl_reg;
      lk_we_next = link_we;
      lk_addr_next = link_addr;
      lk_wdata_next = link_wdata;
    end
  end
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      lk_pend_reg <= 1'b0;
      lk_tgl_reg <= 1'b0;
      lk_we_reg <= 1'b0;
      lk_addr_reg <= 8'h00;
      lk_wdata_reg <= 16'h0000;
      lk_ack_reg <= 1'b0;
      lk_rdata_reg <= 16'h0000;
      ak_s1_reg <= 1'b0;
      ak_s2_reg <= 1'b0;
      ak_s3_reg <= 1'b0;
      ak_seen_reg <= 1'b0;
    end else begin
      lk_pend_reg <= lk_pend_next;
      lk_tgl_reg <= lk_tgl_next;
      lk_we_reg <= lk_we_next;
      lk_addr_reg <= lk_addr_next;
      lk_wdata_reg <= lk_wdata_next;
      lk_ack_reg <= lk_ack_next;
      lk_rdata_reg <= lk_rdata_next;
      ak_s1_reg <= cr_tgl_reg;
      ak_s2_reg <= ak_s1_reg;
      ak_s3_reg <= ak_s2_reg;
      ak_seen_reg <= ak_seen_next;
    end
  end
  assign link_ack = lk_ack_reg;
  assign link_pending = lk_pend_reg;
  assign link_rdata = lk_rdata_reg;

  // ------------------------------------------------------------
  // core side: register file and nvm sequencer
  // ------------------------------------------------------------
  logic rq_s1_reg, rq_s2_reg, rq_s3_reg, rq_seen_reg, rq_seen_next, rq_evt, cr_tgl_next;
  logic [15:0] cr_rdata_next, upper_reg, upper_next, lower_reg, lower_next;
  logic [15:0] scr1_reg, scr1_next, scr2_reg, scr2_next, pg_data_reg, pg_data_next;
  logic unlock_reg, unlock_next, busy_reg, busy_next, wr_hit;
  logic [15:0] cell_reg [NVM_WORDS];
  logic [15:0] cell_next [NVM_WORDS];
  slr_nvm_state_t st_reg, st_next;
  logic [31:0] nvm_cnt_reg, nvm_cnt_next;
  logic [1:0] pg_idx_reg, pg_idx_next, wr_idx;
  always_comb begin
    rq_evt = (rq_s2_reg == rq_s3_reg) && (rq_s2_reg != rq_seen_reg);
    rq_seen_next = rq_evt ? rq_s2_reg : rq_seen_reg;
    cr_tgl_next = rq_evt ? ~cr_tgl_reg : cr_tgl_reg;
    cr_rdata_next = cr_rdata_reg;
    upper_next = upper_reg;
    lower_next = lower_reg;
    scr1_next = scr1_reg;
    scr2_next = scr2_reg;
    unlock_next = unlock_reg;
    cell_next = cell_reg;
    st_next = st_reg;
    nvm_cnt_next = nvm_cnt_reg;
    pg_idx_next = pg_idx_reg;
    pg_data_next = pg_data_reg;
    wr_hit = 1'b0;
    wr_idx = CELL_UPPER;
    if (rq_evt) begin
      if (lk_we_reg) begin
        wr_hit = 1'b1;
        unique case (lk_addr_reg)
          ADDR_UPPER: upper_next = lk_wdata_reg;
          ADDR_LOWER: begin
            lower_next = lk_wdata_reg;
            wr_idx = CELL_LOWER;
          end
          ADDR_SCRATCH1: begin
            scr1_next = lk_wdata_reg;
            wr_idx = CELL_SCR1;
          end
          ADDR_SCRATCH2: begin
            scr2_next = lk_wdata_reg;
            wr_idx = CELL_SCR2;
          end
          ADDR_UNLOCK: begin
            unlock_next = lk_wdata_reg[UNLOCK_BIT];
            wr_hit = 1'b0;
          end
          default: wr_hit = 1'b0;
        endcase
      end else begin
        unique case (lk_addr_reg)
          ADDR_UPPER: cr_rdata_next = upper_reg;
          ADDR_LOWER: cr_rdata_next = lower_reg;
          ADDR_SCRATCH1: cr_rdata_next = scr1_reg;
          ADDR_SCRATCH2: cr_rdata_next = scr2_reg;
          ADDR_UNLOCK: cr_rdata_next = {unlock_reg, busy_reg, 14'h0000};
          default: cr_rdata_next = READ_ZERO;
        endcase
      end
    end
    unique case (st_reg)
      SLR_IDLE: begin
        if (gcall_reset) begin
          st_next = SLR_RELOAD;
          nvm_cnt_next = RELOAD_CYC - 32'h1;
        end else if (wr_hit && unlock_reg) begin
          // writes arriving while busy stay in logic only
          st_next = SLR_PROG;
          nvm_cnt_next = PROG_CYC - 32'h1;
          pg_idx_next = wr_idx;
          pg_data_next = lk_wdata_reg;
        end
      end
      SLR_RELOAD: begin
        if (nvm_cnt_reg == 32'h0) begin
          st_next = SLR_IDLE;
          upper_next = cell_reg[CELL_UPPER];
          lower_next = cell_reg[CELL_LOWER];
          scr1_next = cell_reg[CELL_SCR1];
          scr2_next = cell_reg[CELL_SCR2];
        end else begin
          nvm_cnt_next = nvm_cnt_reg - 32'h1;
        end
      end
      SLR_PROG: begin
        if (nvm_cnt_reg == 32'h0) begin
          st_next = SLR_IDLE;
          cell_next[pg_idx_reg] = pg_data_reg;
        end else begin
          nvm_cnt_next = nvm_cnt_reg - 32'h1;
        end
      end
      // unused code 2'b10: fall back to idle
      default: st_next = SLR_IDLE;
    endcase
    busy_next = (st_next != SLR_IDLE);
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rq_s1_reg <= 1'b0;
      rq_s2_reg <= 1'b0;
      rq_s3_reg <= 1'b0;
      rq_seen_reg <= 1'b0;
      cr_tgl_reg <= 1'b0;
      cr_rdata_reg <= 16'h0000;
      upper_reg <= RST_UPPER;
      lower_reg <= RST_LOWER;
      scr1_reg <= RST_SCRATCH1;
      scr2_reg <= RST_SCRATCH2;
      unlock_reg <= 1'b0;
      // power-up: factory contents, then reload runs
      cell_reg <= '{RST_UPPER, RST_LOWER, SCRATCH1_ID, SCRATCH2_ID};
      st_reg <= SLR_RELOAD;
      nvm_cnt_reg <= RELOAD_CYC - 32'h1;
      pg_idx_reg <= CELL_UPPER;
      pg_data_reg <= 16'h0000;
      busy_reg <= 1'b1;
    end else begin
      rq_s1_reg <= lk_tgl_reg;
      rq_s2_reg <= rq_s1_reg;
      rq_s3_reg <= rq_s2_reg;
      rq_seen_reg <= rq_seen_next;
      cr_tgl_reg <= cr_tgl_next;
      cr_rdata_reg <= cr_rdata_next;
      upper_reg <= upper_next;
      lower_reg <= lower_next;
      scr1_reg <= scr1_next;
      scr2_reg <= scr2_next;
      unlock_reg <= unlock_next;
      cell_reg <= cell_next;
      st_reg <= st_next;
      nvm_cnt_reg <= nvm_cnt_next;
      pg_idx_reg <= pg_idx_next;
      pg_data_reg <= pg_data_next;
      busy_reg <= busy_next;
    end
  end
  assign nvm_busy = busy_reg;

  // ------------------------------------------------------------
  // threshold comparison flags
  // ------------------------------------------------------------
  logic over_reg, over_next, under_reg, under_next;
  always_comb begin
    // set beats a clear in the same cycle
    over_next = flags_clear ? 1'b0 : over_reg;
    under_next = flags_clear ? 1'b0 : under_reg;
    if (result_valid && ($signed(result_data) > $signed(upper_reg))) begin
      over_next = 1'b1;
    end
    if (result_valid && ($signed(result_data) < $signed(lower_reg))) begin
      under_next = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      over_reg <= 1'b0;
      under_reg <= 1'b0;
    end else begin
      over_reg <= over_next;
      under_reg <= under_next;
    end
  end
  assign over_flag = over_reg;
  assign under_flag = under_reg;

  // ------------------------------------------------------------
  // conversion cycle timer
  // ------------------------------------------------------------
  function automatic logic [31:0] eff_period(input logic [2:0] per, input logic [1:0] avg);
    logic [31:0] p, a;
    p = PERIOD_CYC[per];
    a = AVG_MIN_CYC[avg];
    // averaging longer than the period: cycles run back to back
    return (a > p) ? a : p;
  endfunction
  logic [31:0] cyc_cnt_reg, cyc_cnt_next;
  logic cyc_start_reg, cyc_start_next;
  always_comb begin
    cyc_start_next = 1'b0;
    cyc_cnt_next = cyc_cnt_reg;
    if (!continuous_conversion) begin
      // first cycle starts at once when continuous mode resumes
      cyc_cnt_next = 32'h0;
    end else if (cyc_cnt_reg == 32'h0) begin
      cyc_start_next = 1'b1;
      cyc_cnt_next = eff_period(cycle_period_select, average_count_select) - 32'h1;
    end else begin
      cyc_cnt_next = cyc_cnt_reg - 32'h1;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cyc_cnt_reg <= 32'h0;
      cyc_start_reg <= 1'b0;
    end else begin
      cyc_cnt_reg <= cyc_cnt_next;
      cyc_start_reg <= cyc_start_next;
    end
  end
  assign cycle_start = cyc_start_reg;

endmodule

`default_nettype wire

// ===== verification/slr_limit_nvm_sva.sv
`timescale 1ns/1ps
`default_nettype none
module slr_limit_nvm_sva #(
  parameter logic [31:0] PROG_CYC = 32'h0a,
  parameter logic [31:0] RELOAD_CYC = 32'h05
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic gcall_reset,
  input wire logic continuous_conversion,
  input wire logic result_valid,
  input wire logic flags_clear,
  input wire logic cycle_start,
  input wire logic over_flag,
  input wire logic under_flag,
  input wire logic nvm_busy,
  input wire logic link_clk,
  input wire logic link_ack,
  input wire logic link_pending
);
  // ----
  // busy run length, bounded so a stuck busy shows up
  // ----
  logic [31:0] busy_reg;
  logic [31:0] busy_next;
  always_comb begin
    busy_next = nvm_busy ? busy_reg + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 32'h0;
    end else begin
      busy_reg <= busy_next;
    end
  end
  AST_BUSY_BOUND: assert property (@(posedge clk) disable iff (!nrst)
    busy_reg <= PROG_CYC + RELOAD_CYC + 32'h8) else $error("busy held too long");
  AST_GCALL_BUSY: assert property (@(posedge clk) disable iff (!nrst)
    gcall_reset && !nvm_busy |-> ##[1:3] nvm_busy) else $error("no reload after reset call");
  AST_OVER_CAUSE: assert property (@(posedge clk) disable iff (!nrst)
    $rose(over_flag) |-> $past(result_valid)) else $error("over flag without result");
  AST_UNDER_CAUSE: assert property (@(posedge clk) disable iff (!nrst)
    $rose(under_flag) |-> $past(result_valid)) else $error("under flag without result");
  AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
    flags_clear && !result_valid |=> !over_flag && !under_flag) else $error("flags not cleared");
  AST_START_MODE: assert property (@(posedge clk) disable iff (!nrst)
    cycle_start |-> $past(continuous_conversion) ##1 !cycle_start) else $error("stray cycle start");
  AST_START_ENTRY: assert property (@(posedge clk) disable iff (!nrst)
    $rose(continuous_conversion) |=> cycle_start) else $error("no start on mode entry");
  AST_ACK_PULSE: assert property (@(posedge link_clk) disable iff (!nrst)
    link_ack |-> !link_pending ##1 !link_ack) else $error("ack not a single pulse");
  AST_PEND_BOUND: assert property (@(posedge link_clk) disable iff (!nrst)
    link_pending |-> ##[0:20] link_ack) else $error("request never answered");
endmodule
bind slr_limit_nvm slr_limit_nvm_sva #(.PROG_CYC(PROG_CYC), .RELOAD_CYC(RELOAD_CYC))
  i_slr_limit_nvm_sva (.clk(clk), .nrst(nrst), .gcall_reset(gcall_reset),
  .continuous_conversion(continuous_conversion), .result_valid(result_valid),
  .flags_clear(flags_clear), .cycle_start(cycle_start), .over_flag(over_flag),
  .under_flag(under_flag), .nvm_busy(nvm_busy), .link_clk(link_clk), .link_ack(link_ack),
  .link_pending(link_pending));
`default_nettype wire

// ===== verification/slr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module slr_host_model (
  input wire logic link_clk,
  output logic link_req,
  output logic link_we,
  output logic [7:0] link_addr,
  output logic [15:0] link_wdata,
  input wire logic link_ack,
  input wire logic link_pending,
  input wire logic [15:0] link_rdata
);
  import slr_pkg::*;
  initial begin
    link_req = 1'b0;
    link_we = 1'b0;
    link_addr = 8'h00;
    link_wdata = 16'h0000;
  end
  // ----
  // one word per request; released lines show inverted data
  // ----
  task automatic xfer(input logic we, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] r);
    int n;
    r = 'x;
    @(negedge link_clk);
    link_req = 1'b1;
    link_we = we;
    link_addr = a;
    link_wdata = d;
    n = 0;
    // drive and look on the falling edge, away from the launching edge
    do begin @(negedge link_clk); n++; end while (link_pending !== 1'b1 && n < 40);
    link_req = 1'b0;
    link_we = ~we;
    link_addr = ~a;
    link_wdata = ~d;
    n = 0;
    while (link_ack !== 1'b1 && n < 40) begin @(negedge link_clk); n++; end
    if (link_ack === 1'b1) r = link_rdata;
  endtask
  task automatic poll_idle();
    logic [15:0] r;
    int n;
    n = 0;
    do begin xfer(1'b0, ADDR_UNLOCK, 16'h0000, r); n++; end
    while (r[BUSY_BIT] !== 1'b0 && n < 50);
  endtask
endmodule
`default_nettype wire

// ===== verification/slr_limit_nvm_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module slr_limit_nvm_tb_top;
  import slr_pkg::*;
  localparam logic [31:0] PER [8] = '{32'h14, 32'h1e, 32'h28, 32'h32, 32'h3c, 32'h46, 32'h50, 32'h5a};
  localparam logic [31:0] AVG [4] = '{32'h0, 32'h1e, 32'h32, 32'h3c};
  // identifier values are arbitrary
  localparam logic [15:0] ID1 = 16'h3c11;
  localparam logic [15:0] ID2 = 16'h3c22;
  logic clk, nrst, link_clk, gcall_reset, cont, result_valid, flags_clear;
  logic [2:0] per_sel;
  logic [1:0] avg_sel;
  logic [15:0] result_data, link_wdata, link_rdata;
  logic cycle_start, over_flag, under_flag, nvm_busy, link_req, link_we, link_ack, link_pending;
  logic [7:0] link_addr;
  int num_errors = 0;
  int num_checks = 0;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----
  // link clock runs free, offset from the core clock
  // ----
  initial begin
    link_clk = 1'b0;
    #2;
    forever #15 link_clk = ~link_clk;
  end
  slr_limit_nvm #(.PERIOD_CYC(PER), .AVG_MIN_CYC(AVG), .PROG_CYC(32'h190), .RELOAD_CYC(32'h5),
    .SCRATCH1_ID(ID1), .SCRATCH2_ID(ID2)) i_slr_limit_nvm (.clk(clk), .nrst(nrst),
    .gcall_reset(gcall_reset), .continuous_conversion(cont), .cycle_period_select(per_sel),
    .average_count_select(avg_sel), .result_valid(result_valid), .result_data(result_data),
    .flags_clear(flags_clear), .cycle_start(cycle_start), .over_flag(over_flag),
    .under_flag(under_flag), .nvm_busy(nvm_busy), .link_clk(link_clk), .link_req(link_req),
    .link_we(link_we), .link_addr(link_addr), .link_wdata(link_wdata), .link_ack(link_ack),
    .link_pending(link_pending), .link_rdata(link_rdata));
  slr_host_model i_slr_host_model (.link_clk(link_clk), .link_req(link_req), .link_we(link_we),
    .link_addr(link_addr), .link_wdata(link_wdata), .link_ack(link_ack),
    .link_pending(link_pending), .link_rdata(link_rdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] r;
    i_slr_host_model.xfer(1'b0, a, 16'h0000, r);
    check(r, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] r;
    i_slr_host_model.xfer(1'b1, a, d, r);
  endtask
  task automatic gcall();
    @(negedge clk);
    gcall_reset = 1'b1;
    @(negedge clk);
    gcall_reset = 1'b0;
    @(negedge clk);
    check({15'h0, nvm_busy}, 16'h0001);
    i_slr_host_model.poll_idle();
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    i_slr_host_model.poll_idle();
    rchk(ADDR_UPPER, RST_UPPER);
    rchk(ADDR_LOWER, RST_LOWER);
    rchk(ADDR_UNLOCK, READ_ZERO);
    rchk(ADDR_SCRATCH1, ID1);
    rchk(ADDR_SCRATCH2, ID2);
    wr(8'h0a, 16'hffff);
    rchk(8'h0a, READ_ZERO);
  endtask
  task automatic t_locked();
    logic [7:0] a [4];
    logic [15:0] v [4];
    logic [15:0] c [4];
    a = '{ADDR_UPPER, ADDR_LOWER, ADDR_SCRATCH1, ADDR_SCRATCH2};
    v = '{16'h1234, 16'h0ff0, 16'h4321, 16'h0a0a};
    c = '{RST_UPPER, RST_LOWER, ID1, ID2};
    for (int i = 0; i < 4; i++) begin
      wr(a[i], v[i]);
      rchk(a[i], v[i]);
      check({15'h0, nvm_busy}, 16'h0000);
    end
    gcall();
    for (int i = 0; i < 4; i++) begin
      rchk(a[i], c[i]);
    end
  endtask
  task automatic t_unlocked();
    logic [7:0] a [2];
    a = '{ADDR_UPPER, ADDR_SCRATCH2};
    wr(ADDR_UNLOCK, 16'hffff);
    rchk(ADDR_UNLOCK, 16'h8000);
    for (int i = 0; i < 2; i++) begin
      wr(a[i], 16'h0150 + 16'(i));
      rchk(ADDR_UNLOCK, 16'hc000);
      check({15'h0, nvm_busy}, 16'h0001);
      i_slr_host_model.poll_idle();
    end
    wr(ADDR_UNLOCK, 16'h0000);
    gcall();
    rchk(ADDR_UPPER, 16'h0150);
    rchk(ADDR_SCRATCH2, 16'h0151);
  endtask
  task automatic res(input logic [15:0] v, input logic clr, input logic eo, input logic eu);
    @(negedge clk);
    flags_clear = clr;
    @(negedge clk);
    flags_clear = 1'b0;
    result_valid = 1'b1;
    result_data = v;
    @(negedge clk);
    result_valid = 1'b0;
    result_data = ~v;
    check({14'h0, over_flag, under_flag}, {14'h0, eo, eu});
  endtask
  task automatic t_flags();
    wr(ADDR_UPPER, 16'h0100);
    wr(ADDR_LOWER, 16'hff00);
    res(16'h0100, 1'b1, 1'b0, 1'b0);
    res(16'h0101, 1'b0, 1'b1, 1'b0);
    res(16'hff00, 1'b0, 1'b1, 1'b0);
    res(16'hfeff, 1'b1, 1'b0, 1'b1);
    res(16'h7fff, 1'b0, 1'b1, 1'b1);
  endtask
  task automatic t_cycle();
    int n;
    logic [31:0] e;
    for (int c = 0; c < 8; c++) begin
      for (int v = 0; v < 4; v++) begin
        e = (PER[c] > AVG[v]) ? PER[c] : AVG[v];
        @(negedge clk);
        per_sel = c[2:0];
        avg_sel = v[1:0];
        cont = 1'b1;
        n = 0;
        while (cycle_start !== 1'b1 && n < 200) begin @(negedge clk); n++; end
        n = 0;
        do begin @(negedge clk); n++; end while (cycle_start !== 1'b1 && n < 200);
        check(16'(n), e[15:0]);
        cont = 1'b0;
        repeat (3) @(negedge clk);
      end
    end
  endtask
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
  initial begin
    nrst = 1'b0;
    gcall_reset = 1'b0;
    cont = 1'b0;
    result_valid = 1'b0;
    flags_clear = 1'b0;
    per_sel = 3'h0;
    avg_sel = 2'h0;
    result_data = 16'h0000;
    repeat (12) @(negedge clk);
    check({15'h0, nvm_busy}, 16'h0001);
    nrst = 1'b1;
    t_reset();
    t_locked();
    t_unlocked();
    t_flags();
    t_cycle();
    close_out();
  end
endmodule
`default_nettype wire
